// [shared/timer_io_map.svh]
`ifndef TIMER_IO_MAP_SVH
`define TIMER_IO_MAP_SVH
// register offsets
`define IO_TIMER_CH0_3_MODE_CONTROL_ADDR 32'h0080031A
`define IO_TIMER_CH0_3_CLOCK_SELECT_ADDR 32'h0080031D
`define IO_TIMER_CH4_CONTROL_ADDR 32'h0080034A
// reset values
`define IO_TIMER_CH0_3_MODE_CONTROL_RST 16'h0000
`define IO_TIMER_CH0_3_CLOCK_SELECT_RST 8'h00
`define IO_TIMER_CH4_CONTROL_RST 8'h00
// mode control field positions
`define IO_TIMER_CH3_GATE_BIT 0
`define IO_TIMER_CH3_MODE_LSB 1
`define IO_TIMER_CH2_RES_BIT 4
`define IO_TIMER_CH2_MODE_LSB 5
`define IO_TIMER_CH1_RES_BIT 8
`define IO_TIMER_CH1_MODE_LSB 9
`define IO_TIMER_CH0_SRC_BIT 12
`define IO_TIMER_CH0_MODE_LSB 13
// clock select field position inside its byte
`define IO_TIMER_CH0_3_CKS_LSB 6
`define IO_TIMER_CH0_3_CKS_MASK 8'hC0
// channel 4 control field positions
`define IO_TIMER_CH4_CKS_LSB 0
`define IO_TIMER_CH4_GATE_BIT 2
`define IO_TIMER_CH34_SRC_LSB 3
`define IO_TIMER_CH4_MODE_LSB 5
// measure clear reload value
`define IO_TIMER_MEASURE_RELOAD 16'hFFFF
`endif

// [shared/timer_io_pkg.sv]
`default_nettype none
package timer_io_pkg;
  typedef enum logic [2:0] {
    MODE_SINGLE_SHOT = 3'h0,
    MODE_DELAYED_SHOT = 3'h1,
    MODE_CONTINUOUS = 3'h2,
    MODE_PWM = 3'h3,
    MODE_MEASURE_CLEAR = 3'h4,
    MODE_MEASURE_FREE = 3'h5,
    MODE_NOISE = 3'h6
  } mode_t;

  typedef struct packed {
    mode_t mode;
    logic count_tick;
    logic ext_enable;
    logic capture;
    logic reload_ffff;
    logic pwm_reload_sel;
    logic ff_toggle;
  } ch_ctrl_t;

  typedef struct packed {
    logic [31:0] addr;
    logic wr;
    logic rd;
    logic half;
    logic [15:0] wdata;
  } reg_req_t;
endpackage
`default_nettype wire

// [hw/timer_io_channel_control.sv]
`timescale 1ns/10ps
`default_nettype none
`include "timer_io_map.svh"
module timer_io_channel_control (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input var timer_io_pkg::reg_req_t req_i,
  output logic [15:0] reg_rdata_o,
  input wire logic [3:0] clock_bus_i,
  input wire logic [3:0] event_bus_i,
  input wire logic third_external_timer_input_i,
  input wire logic [4:0] start_i,
  input wire logic [4:0] underflow_i,
  output var timer_io_pkg::ch_ctrl_t [4:0] ch_o
);
  logic [15:0] timer_ch0_3_mode_control;
  logic [15:0] read_word;
  logic [4:0] edge_seen;
  logic [4:0] capture_hit;
  logic [4:0] reload_hit;
  logic [4:0] toggle_hit;
  logic [7:0] timer_ch0_3_clock_select;
  logic [7:0] timer_ch4_control;
  logic [2:0] pin_sync;
  logic pin_level;
  logic [4:0] src_prev;
  logic [4:0] src;
  logic [4:0] gate;
  logic [4:0] tick;
  logic [4:0] pwm_sel;
  timer_io_pkg::mode_t mode [5];

  function automatic timer_io_pkg::mode_t decode_mode(input logic [2:0] code);
    case (code)
      3'h0: decode_mode = timer_io_pkg::MODE_SINGLE_SHOT;
      3'h1: decode_mode = timer_io_pkg::MODE_DELAYED_SHOT;
      3'h2: decode_mode = timer_io_pkg::MODE_CONTINUOUS;
      3'h3: decode_mode = timer_io_pkg::MODE_PWM;
      3'h4: decode_mode = timer_io_pkg::MODE_MEASURE_CLEAR;
      3'h5: decode_mode = timer_io_pkg::MODE_MEASURE_FREE;
      default: decode_mode = timer_io_pkg::MODE_NOISE;
    endcase
  endfunction

  function automatic logic pick_bus(input logic [1:0] sel, input logic [3:0] bus);
    pick_bus = bus[sel];
  endfunction

  function automatic logic is_measure(input timer_io_pkg::mode_t m);
    is_measure = (m == timer_io_pkg::MODE_MEASURE_CLEAR) ||
                 (m == timer_io_pkg::MODE_MEASURE_FREE);
  endfunction

  // register writes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_ch0_3_mode_control <= `IO_TIMER_CH0_3_MODE_CONTROL_RST;
    end else if (req_i.wr && req_i.half &&
                 req_i.addr == `IO_TIMER_CH0_3_MODE_CONTROL_ADDR) begin
      timer_ch0_3_mode_control <= req_i.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_ch0_3_clock_select <= `IO_TIMER_CH0_3_CLOCK_SELECT_RST;
    end else if (req_i.wr && req_i.addr == `IO_TIMER_CH0_3_CLOCK_SELECT_ADDR) begin
      timer_ch0_3_clock_select <= req_i.wdata[7:0] & `IO_TIMER_CH0_3_CKS_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_ch4_control <= `IO_TIMER_CH4_CONTROL_RST;
    end else if (req_i.wr && req_i.addr == `IO_TIMER_CH4_CONTROL_ADDR) begin
      timer_ch4_control <= req_i.wdata[7:0];
    end
  end

  // register read selection
  always_comb begin
    case (req_i.addr)
      `IO_TIMER_CH0_3_MODE_CONTROL_ADDR: read_word = timer_ch0_3_mode_control;
      `IO_TIMER_CH0_3_CLOCK_SELECT_ADDR: read_word = {8'h00, timer_ch0_3_clock_select};
      `IO_TIMER_CH4_CONTROL_ADDR: read_word = {8'h00, timer_ch4_control};
      default: read_word = 16'h0000;
    endcase
  end

  // read data holds until the next read
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (req_i.rd) begin
      reg_rdata_o <= read_word;
    end
  end

  // pin synchroniser, three stages
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_sync <= 3'h0;
    end else begin
      pin_sync <= {pin_sync[1:0], third_external_timer_input_i};
    end
  end

  // level accepted once stages two and three agree
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_level <= 1'b0;
    end else if (pin_sync[1] == pin_sync[2]) begin
      pin_level <= pin_sync[2];
    end
  end

  // mode decode
  always_comb begin
    mode[0] = decode_mode(timer_ch0_3_mode_control[`IO_TIMER_CH0_MODE_LSB +: 3]);
    mode[1] = decode_mode(timer_ch0_3_mode_control[`IO_TIMER_CH1_MODE_LSB +: 3]);
    mode[2] = decode_mode(timer_ch0_3_mode_control[`IO_TIMER_CH2_MODE_LSB +: 3]);
    mode[3] = decode_mode(timer_ch0_3_mode_control[`IO_TIMER_CH3_MODE_LSB +: 3]);
    mode[4] = decode_mode(timer_ch4_control[`IO_TIMER_CH4_MODE_LSB +: 3]);
  end

  // enable/measure sources, none for ch1 and ch2
  always_comb begin
    src = 5'h00;
    src[0] = timer_ch0_3_mode_control[`IO_TIMER_CH0_SRC_BIT] & pin_level;
    if (timer_ch4_control[`IO_TIMER_CH34_SRC_LSB + 1]) begin
      src[3] = event_bus_i[{1'b1, timer_ch4_control[`IO_TIMER_CH34_SRC_LSB]}];
      src[4] = src[3];
    end
  end

  // external input gates, ch0 always on
  always_comb begin
    gate = 5'h00;
    gate[0] = 1'b1;
    gate[3] = timer_ch0_3_mode_control[`IO_TIMER_CH3_GATE_BIT];
    gate[4] = timer_ch4_control[`IO_TIMER_CH4_GATE_BIT];
  end

  // count clock selection
  always_comb begin
    tick = 5'h00;
    for (int i = 0; i < 4; i++) begin
      tick[i] = pick_bus(timer_ch0_3_clock_select[`IO_TIMER_CH0_3_CKS_LSB +: 2],
                         clock_bus_i);
    end
    tick[4] = pick_bus(timer_ch4_control[`IO_TIMER_CH4_CKS_LSB +: 2], clock_bus_i);
  end

  // source edges, capture, reload and toggle requests
  always_comb begin
    edge_seen = src & ~src_prev;
    capture_hit = 5'h00;
    reload_hit = 5'h00;
    toggle_hit = 5'h00;
    for (int i = 0; i < 5; i++) begin
      capture_hit[i] = edge_seen[i] & is_measure(mode[i]);
      reload_hit[i] = edge_seen[i] & gate[i] &
                      (mode[i] == timer_io_pkg::MODE_MEASURE_CLEAR);
      toggle_hit[i] = (start_i[i] | underflow_i[i]) &
                      (mode[i] == timer_io_pkg::MODE_PWM);
    end
  end

  // previous source levels for edge detection
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src_prev <= 5'h00;
    end else begin
      src_prev <= src;
    end
  end

  // pwm reload alternation
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwm_sel <= 5'h00;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (mode[i] != timer_io_pkg::MODE_PWM || start_i[i]) begin
          pwm_sel[i] <= 1'b0;
        end else if (underflow_i[i]) begin
          pwm_sel[i] <= ~pwm_sel[i];
        end
      end
    end
  end

  // channel control outputs
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ch_o <= '0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        ch_o[i].mode <= mode[i];
        ch_o[i].count_tick <= tick[i];
        ch_o[i].ext_enable <= gate[i] & src[i];
        ch_o[i].capture <= capture_hit[i];
        ch_o[i].reload_ffff <= reload_hit[i];
        ch_o[i].pwm_reload_sel <= pwm_sel[i];
        ch_o[i].ff_toggle <= toggle_hit[i];
      end
    end
  end
endmodule // timer_io_channel_control
`default_nettype wire

// [bench/timer_io_channel_control_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module io_timer_checker (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input var timer_io_pkg::reg_req_t req_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [3:0] clock_bus_i,
  input wire logic [3:0] event_bus_i,
  input wire logic third_external_timer_input_i,
  input wire logic [4:0] start_i,
  input wire logic [4:0] underflow_i,
  input var timer_io_pkg::ch_ctrl_t [4:0] ch_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_nocap; !(ch_o[1].capture || ch_o[2].capture); endproperty
  a_nocap: assert property (p_nocap) else $error("ch1 or ch2 captured");
  property p_noext; !(ch_o[1].ext_enable || ch_o[2].ext_enable); endproperty
  a_noext: assert property (p_noext) else $error("reserved source acted");
  property p_tick; ch_o[0].count_tick == ch_o[3].count_tick; endproperty
  a_tick: assert property (p_tick) else $error("ch0 and ch3 ticks differ");
  property p_tick4; ch_o[4].count_tick |-> $past(|clock_bus_i); endproperty
  a_tick4: assert property (p_tick4) else $error("ch4 tick without bus");
  property p_rel; ch_o[3].reload_ffff |-> ch_o[3].mode == timer_io_pkg::MODE_MEASURE_CLEAR;
  endproperty
  a_rel: assert property (p_rel) else $error("reload outside clear mode");
  property p_cap; ch_o[0].capture |-> ch_o[0].mode[2:1] == 2'b10; endproperty
  a_cap: assert property (p_cap) else $error("capture outside measure");
  property p_ff; ch_o[4].ff_toggle |-> $past(start_i[4] | underflow_i[4]); endproperty
  a_ff: assert property (p_ff) else $error("toggle without cause");
  property p_rd; req_i.rd && req_i.addr == 32'h00800300 |=> reg_rdata_o == 16'h0000;
  endproperty
  a_rd: assert property (p_rd) else $error("unmapped read not zero");
endmodule // io_timer_checker
bind timer_io_channel_control io_timer_checker i_io_timer_checker (.clk_i(clk_i),
  .arst_n_i(arst_n_i),
  .req_i(req_i), .reg_rdata_o(reg_rdata_o), .clock_bus_i(clock_bus_i),
  .event_bus_i(event_bus_i), .third_external_timer_input_i(third_external_timer_input_i),
  .start_i(start_i), .underflow_i(underflow_i), .ch_o(ch_o));
`default_nettype wire

// [bench/tio_far_side.sv]
`timescale 1ns/10ps
`default_nettype none
module io_timer_far_side (
  input wire logic clk_i,
  input wire logic [4:0] fire_i,
  output logic [3:0] clock_bus_o,
  output logic [3:0] event_bus_o,
  output logic pin_o
);
  logic [7:0] cnt = 8'h00;
  always_ff @(posedge clk_i) cnt <= cnt + 8'h01;
  // capture lines follow the bench request
  always_ff @(posedge clk_i) {pin_o, event_bus_o} <= fire_i;
  // bus k pulses every k+2 cycles
  always_comb begin
    for (int k = 0; k < 4; k++) clock_bus_o[k] = cnt % 8'(k + 2) == 8'h00;
  end
endmodule // io_timer_far_side
`default_nettype wire

// [bench/test_timer_io_channel_control.sv]
`timescale 1ns/10ps
`default_nettype none
`include "timer_io_map.svh"
module test_timer_io_channel_control;
  localparam logic [31:0] MC = `IO_TIMER_CH0_3_MODE_CONTROL_ADDR;
  localparam logic [31:0] CK = `IO_TIMER_CH0_3_CLOCK_SELECT_ADDR;
  localparam logic [31:0] C4 = `IO_TIMER_CH4_CONTROL_ADDR;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  timer_io_pkg::reg_req_t req = '0;
  timer_io_pkg::ch_ctrl_t [4:0] ch;
  logic [15:0] rdata;
  logic [3:0] cb, eb;
  logic pin;
  logic [4:0] fire = '0, st = '0, uf = '0;
  int fail_count = 0, n_tests = 0;
  always #25 clk_i = ~clk_i;
  io_timer_far_side i_io_timer_far_side (.clk_i(clk_i), .fire_i(fire), .clock_bus_o(cb),
    .event_bus_o(eb), .pin_o(pin));
  timer_io_channel_control i_timer_io_channel_control (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .req_i(req), .reg_rdata_o(rdata), .clock_bus_i(cb), .event_bus_i(eb),
    .third_external_timer_input_i(pin), .start_i(st), .underflow_i(uf), .ch_o(ch));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic h);
    @(posedge clk_i) req <= '{a, 1'b1, 1'b0, h, d};
    @(posedge clk_i) req.wr <= 1'b0;
    @(posedge clk_i) #1;
  endtask
  task automatic rd(input string n, input logic [31:0] a, input logic [15:0] e);
    @(posedge clk_i) req <= '{a, 1'b0, 1'b1, 1'b1, 16'h0000};
    @(posedge clk_i) req.rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  task automatic t_regs();
    rd("mc", MC, `IO_TIMER_CH0_3_MODE_CONTROL_RST);
    rd("ck", CK, `IO_TIMER_CH0_3_CLOCK_SELECT_RST);
    rd("c4", C4, `IO_TIMER_CH4_CONTROL_RST);
    wr(MC, 16'h0110, 1'b1);
    wr(MC, 16'hFFFF, 1'b0);
    rd("mc", MC, 16'h0110);
    wr(CK, 16'h00FF, 1'b0);
    rd("ck", CK, 16'h00C0);
    rd("none", 32'h00800300, 16'h0000);
  endtask
  task automatic t_modes();
    logic [2:0] e, m12;
    for (int c = 0; c < 8; c++) begin
      e = (c > 5) ? 3'h6 : 3'(c);
      m12 = (c > 5) ? 3'h0 : 3'(c);
      wr(MC, {3'(c), 1'b0, m12, 1'b0, m12, 1'b0, 3'(c), 1'b0}, 1'b1);
      wr(C4, {8'h00, 3'(c), 5'h00}, 1'b0);
      chk("m0", 16'(e), 16'(ch[0].mode));
      chk("m1", 16'(m12), 16'(ch[1].mode));
      chk("m2", 16'(m12), 16'(ch[2].mode));
      chk("m3", 16'(e), 16'(ch[3].mode));
      chk("m4", 16'(e), 16'(ch[4].mode));
    end
  endtask
  task automatic t_clk();
    logic b;
    for (int k = 0; k < 4; k++) begin
      wr(CK, {8'h00, 2'(k), 6'h00}, 1'b0);
      wr(C4, 16'(k), 1'b0);
      for (int i = 0; i < 8; i++) begin
        b = cb[k];
        @(posedge clk_i) #1 chk("t0", b, ch[0].count_tick);
        chk("t1", b, ch[1].count_tick);
        chk("t2", b, ch[2].count_tick);
        chk("t3", b, ch[3].count_tick);
        chk("t4", b, ch[4].count_tick);
      end
    end
  endtask
  task automatic t_cap(input logic g);
    int c0, c3, c4, r;
    c0 = 0;
    c3 = 0;
    c4 = 0;
    r = 0;
    wr(MC, 16'hB888 | 16'(g), 1'b1);
    wr(C4, 16'h0090 | {13'h0000, g, 2'h0}, 1'b0);
    @(posedge clk_i) fire <= 5'h14;
    repeat (12) begin
      @(posedge clk_i) #1 c0 += ch[0].capture;
      c3 += ch[3].capture;
      c4 += ch[4].capture;
      r += ch[3].reload_ffff + ch[4].reload_ffff;
    end
    chk("e0", 16'h0001, ch[0].ext_enable);
    chk("e3", 16'(g), ch[3].ext_enable);
    chk("e4", 16'(g), ch[4].ext_enable);
    @(posedge clk_i) fire <= 5'h00;
    chk("c0", 16'h0001, 16'(c0));
    chk("c3", 16'h0001, 16'(c3));
    chk("c4", 16'h0001, 16'(c4));
    chk("rl", g ? 16'h0002 : 16'h0000, 16'(r));
  endtask
  task automatic t_pwm();
    logic n;
    wr(C4, 16'h0060, 1'b0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i) if (i == 0) st <= 5'h10; else uf <= 5'h10;
      @(posedge clk_i) st <= 5'h00;
      uf <= 5'h00;
      #1 n = ch[4].ff_toggle;
      repeat (2) @(posedge clk_i);
      #1 chk("ff", 16'h0001, n);
      chk("sel", 16'(i % 2), ch[4].pwm_reload_sel);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // the run needs some 185 cycles
  initial begin
    #100000 fail_count++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_modes();
    t_clk();
    t_cap(1'b0);
    t_cap(1'b1);
    t_pwm();
    print_verdict();
  end
endmodule // test_timer_io_channel_control
`default_nettype wire
